// File: logic/scan_decode.sv
// Boundary-scan instruction decode and data register selection.
// Assumes test pins are asynchronous and test clock is far slower than ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
module scan_decode #(
  parameter logic [3:0] DIE_VERSION = 4'h0,       // Arbitrary value
  parameter logic [6:0] FAMILY_CODE = 7'h00,      // Arbitrary value
  parameter logic [8:0] ROW_COUNT = 9'h000,       // Array rows
  parameter logic [7:0] COMPANY_CODE = 8'h00      // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Test port pins
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  // Configuration state
  input wire logic [31:0] usercode_in,
  input wire logic config_done_in,
  input wire logic startup_sequence_clock_select_in,
  // User register path
  input wire logic user_tdo_one_in,
  input wire logic user_tdo_two_in,
  output logic user_sel_one_out,
  output logic user_sel_two_out,
  output logic dr_capture_out,
  output logic dr_shift_out,
  output logic dr_update_out,
  output logic dr_tdi_out,
  // Configuration bus path
  input wire logic cfg_tdo_in,
  output logic cfg_read_out,
  output logic cfg_write_out,
  // Boundary register and pin control
  input wire logic bsr_tdo_in,
  output logic bsr_sel_out,
  output logic extest_out,
  output logic intest_out,
  output logic sample_out,
  output logic highz_out,
  output logic startup_step_via_test_clock_out
);

  // ********************************
  // Pin synchronisers and edges
  // ********************************
  scan_pkg::tap_pins_t meta_reg;
  scan_pkg::tap_pins_t sync_reg;
  logic tck_prev_reg;
  logic tck_rise;
  logic tck_fall;

  // Two flops ahead of any logic
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
      tck_prev_reg <= 1'b0;
    end else begin
      meta_reg <= '{tck: tck_in, tms: tms_in, tdi: tdi_in};
      sync_reg <= meta_reg;
      tck_prev_reg <= sync_reg.tck;
    end
  end

  assign tck_rise = sync_reg.tck & ~tck_prev_reg;
  assign tck_fall = ~sync_reg.tck & tck_prev_reg;

  // ********************************
  // Controller
  // ********************************
  logic st_reset;
  logic cap_dr;
  logic sh_dr;
  logic up_dr;
  logic cap_ir;
  logic sh_ir;
  logic up_ir;

  tap_fsm i_tap_fsm (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .tck_rise_in(tck_rise),
    .tms_in(sync_reg.tms),
    .reset_out(st_reset),
    .capture_dr_out(cap_dr),
    .shift_dr_out(sh_dr),
    .update_dr_out(up_dr),
    .capture_ir_out(cap_ir),
    .shift_ir_out(sh_ir),
    .update_ir_out(up_ir)
  );

  // ********************************
  // Instruction register
  // ********************************
  logic [4:0] ir_shift_reg;
  logic [4:0] ir_reg;

  // Shift on rise, load on rise leaving update; reset forces identification
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ir_shift_reg <= scan_pkg::INSTR_CAPTURE;
      ir_reg <= scan_pkg::INSTR_DEVID;
    end else if (st_reset) begin
      ir_reg <= scan_pkg::INSTR_DEVID;
    end else if (tck_rise) begin
      if (cap_ir) ir_shift_reg <= scan_pkg::INSTR_CAPTURE;
      else if (sh_ir) ir_shift_reg <= {sync_reg.tdi, ir_shift_reg[4:1]};
      if (up_ir) ir_reg <= ir_shift_reg;
    end
  end

  // Decode shared by every output path
  function automatic scan_pkg::instr_dec_t decode(input logic [4:0] code);
    scan_pkg::instr_dec_t d;
    d = '{sel: scan_pkg::SEL_BYPASS, default: 1'b0};
    case (code)
      scan_pkg::INSTR_EXTEST: begin d.sel = scan_pkg::SEL_BOUNDARY; d.extest = 1'b1; end
      scan_pkg::INSTR_SAMPLE: begin d.sel = scan_pkg::SEL_BOUNDARY; d.sample = 1'b1; end
      scan_pkg::INSTR_USER_ONE: d.sel = scan_pkg::SEL_USER_ONE;
      scan_pkg::INSTR_USER_TWO: d.sel = scan_pkg::SEL_USER_TWO;
      scan_pkg::INSTR_CFG_READ: begin d.sel = scan_pkg::SEL_CFG; d.cfg_read = 1'b1; end
      scan_pkg::INSTR_CFG_WRITE: begin d.sel = scan_pkg::SEL_CFG; d.cfg_write = 1'b1; end
      scan_pkg::INSTR_INTEST: begin d.sel = scan_pkg::SEL_BOUNDARY; d.intest = 1'b1; end
      scan_pkg::INSTR_USERID: d.sel = scan_pkg::SEL_USERID;
      scan_pkg::INSTR_DEVID: d.sel = scan_pkg::SEL_DEVID;
      scan_pkg::INSTR_HIGHZ: begin d.sel = scan_pkg::SEL_BYPASS; d.highz = 1'b1; end
      scan_pkg::INSTR_STARTUP: begin d.sel = scan_pkg::SEL_BYPASS; d.startup = 1'b1; end
      default: d.sel = scan_pkg::SEL_BYPASS;
    endcase
    return d;
  endfunction : decode

  scan_pkg::instr_dec_t dec;
  assign dec = decode(ir_reg);

  // ********************************
  // Internal data registers
  // ********************************
  logic [31:0] id_word;
  logic [31:0] dr_shift_reg;
  logic bypass_reg;

  // Fixed identity word with bit 0 tied high; fields sit at fixed positions so the word stays 32 bits
  // The company code is narrower than its slot, so the three bits above it stay clear
  assign id_word = (32'(DIE_VERSION) << scan_pkg::ID_VER_LSB) | (32'(FAMILY_CODE) << scan_pkg::ID_FAM_LSB) |
    (32'(ROW_COUNT) << scan_pkg::ID_ROWS_LSB) | (32'(COMPANY_CODE) << scan_pkg::ID_CO_LSB) | 32'h0000_0001;

  // Capture then shift the selected internal register
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dr_shift_reg <= '0;
      bypass_reg <= 1'b0;
    end else if (tck_rise) begin
      if (cap_dr) begin
        bypass_reg <= 1'b0;
        case (dec.sel)
          scan_pkg::SEL_DEVID: dr_shift_reg <= id_word;
          // Before configuration the user word is not trusted, so all ones go out
          scan_pkg::SEL_USERID: dr_shift_reg <= config_done_in ? usercode_in : '1;
          default: dr_shift_reg <= '0;
        endcase
      end else if (sh_dr) begin
        bypass_reg <= sync_reg.tdi;
        dr_shift_reg <= {sync_reg.tdi, dr_shift_reg[31:1]};
      end
    end
  end

  // ********************************
  // Serial output, changed on fall
  // ********************************
  logic tdo_next;
  logic tdo_reg;
  logic tdo_oe_reg;

  // Select the serial source for the active path
  always_comb begin
    tdo_next = bypass_reg;
    if (sh_ir) begin
      tdo_next = ir_shift_reg[0];
    end else begin
      case (dec.sel)
        scan_pkg::SEL_BOUNDARY: tdo_next = bsr_tdo_in;
        scan_pkg::SEL_USER_ONE: tdo_next = user_tdo_one_in;
        scan_pkg::SEL_USER_TWO: tdo_next = user_tdo_two_in;
        scan_pkg::SEL_CFG: tdo_next = cfg_tdo_in;
        scan_pkg::SEL_USERID, scan_pkg::SEL_DEVID: tdo_next = dr_shift_reg[0];
        default: tdo_next = bypass_reg;
      endcase
    end
  end

  // Output driven only while shifting, updated on test-clock fall
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_reg <= tdo_next;
      tdo_oe_reg <= sh_dr | sh_ir;
    end
  end

  // ********************************
  // Control outputs
  // ********************************
  assign tdo_out = tdo_reg;
  assign tdo_oe_out = tdo_oe_reg;
  assign user_sel_one_out = (dec.sel == scan_pkg::SEL_USER_ONE);
  assign user_sel_two_out = (dec.sel == scan_pkg::SEL_USER_TWO);
  assign dr_capture_out = cap_dr & tck_rise;
  assign dr_shift_out = sh_dr & tck_rise;
  assign dr_update_out = up_dr & tck_rise;
  assign dr_tdi_out = sync_reg.tdi;
  assign cfg_read_out = dec.cfg_read;
  assign cfg_write_out = dec.cfg_write;
  assign bsr_sel_out = (dec.sel == scan_pkg::SEL_BOUNDARY);
  assign extest_out = dec.extest;
  assign intest_out = dec.intest;
  assign sample_out = dec.sample;
  assign highz_out = dec.highz;
  // Step on every test-clock rise in any controller state while start-up is decoded and the start-up clock is taken from the test clock
  assign startup_step_via_test_clock_out = dec.startup & startup_sequence_clock_select_in & tck_rise;

endmodule : scan_decode
`default_nettype wire

// File: logic/scan_pkg.sv
// Package for the boundary-scan instruction decode block.
// Assumes a single clock domain; test pins arrive asynchronously.
package scan_pkg;

  // ********************************
  // Instruction codes
  // ********************************
  localparam int INSTR_W = 5;
  localparam logic [4:0] INSTR_EXTEST = 5'h00;
  localparam logic [4:0] INSTR_SAMPLE = 5'h01;
  localparam logic [4:0] INSTR_USER_ONE = 5'h02;
  localparam logic [4:0] INSTR_USER_TWO = 5'h03;
  localparam logic [4:0] INSTR_CFG_READ = 5'h04;
  localparam logic [4:0] INSTR_CFG_WRITE = 5'h05;
  localparam logic [4:0] INSTR_INTEST = 5'h07;
  localparam logic [4:0] INSTR_USERID = 5'h08;
  localparam logic [4:0] INSTR_DEVID = 5'h09;
  localparam logic [4:0] INSTR_HIGHZ = 5'h0a;
  localparam logic [4:0] INSTR_STARTUP = 5'h0c;
  localparam logic [4:0] INSTR_BYPASS = 5'h1f;
  // Instruction capture pattern (low two bits 01)
  localparam logic [4:0] INSTR_CAPTURE = 5'h01;

  // ********************************
  // Identification layout
  // ********************************
  localparam int ID_W = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_FAM_LSB = 21;
  localparam int ID_ROWS_LSB = 12;
  localparam int ID_CO_LSB = 1;
  localparam int DR_W = 32;
  localparam logic [5:0] DR_CNT_ONE = 6'h01;

  // ********************************
  // Data register selection
  // ********************************
  typedef enum logic [2:0] {
    SEL_BOUNDARY, SEL_USER_ONE, SEL_USER_TWO, SEL_CFG, SEL_USERID, SEL_DEVID, SEL_BYPASS
  } dr_sel_t;

  // Decoded instruction
  typedef struct packed {
    dr_sel_t sel;
    logic extest;
    logic intest;
    logic sample;
    logic cfg_read;
    logic cfg_write;
    logic highz;
    logic startup;
  } instr_dec_t;

  // Test pins after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;

endpackage : scan_pkg

// File: logic/tap_fsm.sv
// Sixteen-state test access port controller.
// Assumes tck_rise_in is a one-cycle pulse per synchronised test-clock rise.
`timescale 1ns/1ps
`default_nettype none
module tap_fsm (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Sampled pins
  input wire logic tck_rise_in,
  input wire logic tms_in,
  // Controller state flags
  output logic reset_out,
  output logic capture_dr_out,
  output logic shift_dr_out,
  output logic update_dr_out,
  output logic capture_ir_out,
  output logic shift_ir_out,
  output logic update_ir_out
);

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UP_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
  } tap_state_t;

  tap_state_t state_reg;
  tap_state_t state_next;

  // Standard transition table, moved only on test-clock rise
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: state_next = tms_in ? ST_RESET : ST_IDLE;
      ST_IDLE: state_next = tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tms_in ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_next = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms_in ? ST_UP_DR : ST_PA_DR;
      ST_PA_DR: state_next = tms_in ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_next = tms_in ? ST_UP_DR : ST_SH_DR;
      ST_UP_DR: state_next = tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tms_in ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_next = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_next = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms_in ? ST_UP_IR : ST_PA_IR;
      ST_PA_IR: state_next = tms_in ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_next = tms_in ? ST_UP_IR : ST_SH_IR;
      ST_UP_IR: state_next = tms_in ? ST_SEL_DR : ST_IDLE;
      default: state_next = ST_RESET;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_RESET;
    end else if (tck_rise_in) begin
      state_reg <= state_next;
    end
  end

  // Flags decoded from the present state
  assign reset_out = (state_reg == ST_RESET);
  assign capture_dr_out = (state_reg == ST_CAP_DR);
  assign shift_dr_out = (state_reg == ST_SH_DR);
  assign update_dr_out = (state_reg == ST_UP_DR);
  assign capture_ir_out = (state_reg == ST_CAP_IR);
  assign shift_ir_out = (state_reg == ST_SH_IR);
  assign update_ir_out = (state_reg == ST_UP_IR);

endmodule : tap_fsm
`default_nettype wire

// File: tb/scan_decode_assertions.sv
// Concurrent checks on the scan decode ports.
// Assumes a single ref_clk_in domain and slow test-clock pins.
`timescale 1ns/1ps
`default_nettype none
module scan_decode_checker (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Observed ports
  input wire logic tck_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire logic startup_sequence_clock_select_in,
  input wire logic user_sel_one_out,
  input wire logic user_sel_two_out,
  input wire logic dr_capture_out,
  input wire logic dr_shift_out,
  input wire logic dr_update_out,
  input wire logic cfg_read_out,
  input wire logic cfg_write_out,
  input wire logic bsr_sel_out,
  input wire logic extest_out,
  input wire logic intest_out,
  input wire logic sample_out,
  input wire logic highz_out,
  input wire logic startup_step_via_test_clock_out
);
  // ********************************
  // Sequences and properties
  // ********************************
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Strobes come only after the synchroniser has seen tck high
  sequence s_tck_settled;
    tck_in && $past(tck_in);
  endsequence
  sequence s_dr_strobe;
    dr_capture_out || dr_shift_out || dr_update_out;
  endsequence
  property p_extest; extest_out |-> bsr_sel_out && !intest_out && !sample_out; endproperty
  a_extest: assert property (p_extest) else $error("extest off boundary path");
  property p_sample; sample_out |-> bsr_sel_out && !extest_out; endproperty
  a_sample: assert property (p_sample) else $error("sample off boundary path");
  property p_intest; intest_out |-> bsr_sel_out && !sample_out; endproperty
  a_intest: assert property (p_intest) else $error("intest off boundary path");
  property p_user; user_sel_one_out |-> !user_sel_two_out && !bsr_sel_out; endproperty
  a_user: assert property (p_user) else $error("two user paths at once");
  property p_cfg; cfg_read_out |-> !cfg_write_out && !bsr_sel_out; endproperty
  a_cfg: assert property (p_cfg) else $error("config read and write together");
  property p_highz; highz_out |-> !bsr_sel_out && !user_sel_one_out && !user_sel_two_out && !cfg_read_out; endproperty
  a_highz: assert property (p_highz) else $error("float without bypass");
  property p_step;
    startup_step_via_test_clock_out |-> startup_sequence_clock_select_in ##1 !startup_step_via_test_clock_out;
  endproperty
  a_step: assert property (p_step) else $error("bad start-up step");
  property p_reset_id; $fell(sys_rst_in) |-> !bsr_sel_out && !highz_out && !user_sel_one_out && !tdo_oe_out; endproperty
  a_reset_id: assert property (p_reset_id) else $error("reset not on id path");
  property p_tdo_fall; $changed(tdo_out) |-> !tck_in; endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved while tck high");
  property p_oe; dr_capture_out || dr_update_out |-> !tdo_oe_out; endproperty
  a_oe: assert property (p_oe) else $error("tdo driven outside shift");
  property p_strobe; s_dr_strobe |-> s_tck_settled; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without tck rise");
endmodule : scan_decode_checker
bind scan_decode scan_decode_checker i_scan_decode_checker (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .tck_in(tck_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
  .startup_sequence_clock_select_in(startup_sequence_clock_select_in), .user_sel_one_out(user_sel_one_out),
  .user_sel_two_out(user_sel_two_out), .dr_capture_out(dr_capture_out), .dr_shift_out(dr_shift_out),
  .dr_update_out(dr_update_out), .cfg_read_out(cfg_read_out), .cfg_write_out(cfg_write_out),
  .bsr_sel_out(bsr_sel_out), .extest_out(extest_out), .intest_out(intest_out), .sample_out(sample_out),
  .highz_out(highz_out), .startup_step_via_test_clock_out(startup_step_via_test_clock_out));
`default_nettype wire

// File: tb/jtag_ctrl_model.sv
// Behavioural external test controller on the scan pins.
// Assumes ref_clk_in at 40 MHz; pins move on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module jtag_ctrl_model (
  // Clock
  input wire logic ref_clk_in,
  // Scan pins
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  // ********************************
  // Pin sequencing
  // ********************************
  // One 200 ns tck cycle; tck rests low between frames
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    repeat (4) @(negedge ref_clk_in);
    tdo = tdo_in;
    tck_out = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    tck_out = 1'b0;
  endtask : tick
  // Five ones on tms reach Test-Logic-Reset from any state
  task automatic reset_tap();
    logic d;
    repeat (5) tick(1'b1, tdi_out, d);
    tick(1'b0, tdi_out, d);
  endtask : reset_tap
  // Idle to shift, n bits LSB first, then update and back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic d;
    dout = '0;
    tick(1'b1, tdi_out, d);
    if (ir) tick(1'b1, tdi_out, d);
    tick(1'b0, tdi_out, d);
    tick(1'b0, tdi_out, d);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    // Last bit inverted after release, so a stale input is not mistaken for data
    tick(1'b1, ~din[n - 1], d);
    tick(1'b0, tdi_out, d);
  endtask : scan
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
endmodule : jtag_ctrl_model
`default_nettype wire

// File: tb/tb_scan_decode.sv
// Self-checking bench for the scan instruction decode.
// Assumes the controller model owns the scan pins.
`timescale 1ns/1ps
`default_nettype none
module tb_scan_decode;
  // ********************************
  // Signals and instances
  // ********************************
  localparam logic [3:0] VER = 4'h3;  // Arbitrary value
  localparam logic [6:0] FAM = 7'h15;  // Arbitrary value
  localparam logic [8:0] ROWS = 9'h0a5;
  localparam logic [7:0] CO = 8'h5b;  // Arbitrary value
  localparam logic [31:0] ID_WORD = (32'(VER) << scan_pkg::ID_VER_LSB) | (32'(FAM) << scan_pkg::ID_FAM_LSB) |
    (32'(ROWS) << scan_pkg::ID_ROWS_LSB) | (32'(CO) << scan_pkg::ID_CO_LSB) | 32'h0000_0001;
  localparam logic [31:0] USER_WORD = 32'h1234_56c3;
  logic ref_clk_in, sys_rst_in, tck, tms, tdi, tdo, done, clk_sel, sel1, sel2;
  logic cfg_r, cfg_w, bsr_sel, extest, intest, sample, highz, step;
  logic tdo_oe, tdo_pin, dr_sh, dr_tdi;
  int shifts = 0;
  int errors = 0;
  int total_checks = 0;
  int steps = 0;
  scan_decode #(.DIE_VERSION(VER), .FAMILY_CODE(FAM), .ROW_COUNT(ROWS), .COMPANY_CODE(CO)) i_scan_decode (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo), .tdo_oe_out(tdo_oe), .usercode_in(USER_WORD), .config_done_in(done),
    // Fixed returns stand in for user registers that user logic wires up only when wanted
    .startup_sequence_clock_select_in(clk_sel), .user_tdo_one_in(1'b1), .user_tdo_two_in(1'b0),
    .user_sel_one_out(sel1), .user_sel_two_out(sel2), .dr_capture_out(), .dr_shift_out(dr_sh),
    .dr_update_out(), .dr_tdi_out(dr_tdi), .cfg_tdo_in(1'b1), .cfg_read_out(cfg_r), .cfg_write_out(cfg_w),
    .bsr_tdo_in(1'b0), .bsr_sel_out(bsr_sel), .extest_out(extest), .intest_out(intest),
    .sample_out(sample), .highz_out(highz), .startup_step_via_test_clock_out(step));
  jtag_ctrl_model i_jtag_ctrl_model (.ref_clk_in(ref_clk_in), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .tdo_in(tdo_pin));
  // Released serial output floats to its pull-up level at the controller
  assign tdo_pin = tdo_oe ? tdo : 1'b1;
  always @(posedge ref_clk_in) if (step) steps++;
  always @(posedge ref_clk_in) if (dr_sh) shifts++;
  // ********************************
  // Checking helpers
  // ********************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // Levels {bsr,extest,intest,sample,user1,user2,cfg_r,cfg_w,highz}, first DR byte for tdi 96
  function automatic logic [16:0] expect_of(input logic [4:0] c);
    case (c)
      5'h00: return {9'h180, 8'h00};
      5'h01: return {9'h120, 8'h00};
      5'h02: return {9'h010, 8'hff};
      5'h03: return {9'h008, 8'h00};
      5'h04: return {9'h004, 8'hff};
      5'h05: return {9'h002, 8'hff};
      5'h07: return {9'h140, 8'h00};
      5'h08: return {9'h000, USER_WORD[7:0]};
      5'h09: return {9'h000, ID_WORD[7:0]};
      5'h0a: return {9'h001, 8'h2c};
      default: return {9'h000, 8'h2c};  // Bypass: capture 0 then tdi
    endcase
  endfunction : expect_of
  // ********************************
  // Scenarios
  // ********************************
  // Controller leaves reset through run-test-idle, then the id word must come out
  task automatic t_power_on();
    logic [31:0] d;
    i_jtag_ctrl_model.reset_tap();
    i_jtag_ctrl_model.scan(1'b0, 32, 32'h0000_0000, d);
    chk("id_after_reset", d, ID_WORD);
  endtask : t_power_on
  task automatic t_decode();
    logic [4:0] codes [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0c,
      5'h06, 5'h1f};
    logic [31:0] d;
    logic [16:0] e;
    for (int k = 0; k < 13; k++) begin
      e = expect_of(codes[k]);
      i_jtag_ctrl_model.scan(1'b1, 5, 32'(codes[k]), d);
      chk("ir_capture", d, 32'h0000_0001);
      chk("levels", 32'({bsr_sel, extest, intest, sample, sel1, sel2, cfg_r, cfg_w, highz}), 32'(e[16:8]));
      if (codes[k] != 5'h0c) begin
        i_jtag_ctrl_model.scan(1'b0, 8, 32'h0000_0096, d);
        chk("dr_byte", d, 32'(e[7:0]));
      end
    end
  endtask : t_decode
  task automatic t_startup();
    logic [31:0] d;
    logic b;
    i_jtag_ctrl_model.scan(1'b1, 5, 32'h0000_000c, d);
    steps = 0;
    repeat (3) i_jtag_ctrl_model.tick(1'b0, 1'b1, b);
    chk("steps_off", 32'(steps), 32'h0000_0000);
    clk_sel = 1'b1;
    repeat (4) i_jtag_ctrl_model.tick(1'b0, 1'b1, b);
    chk("steps_on", 32'(steps), 32'h0000_0004);
    clk_sel = 1'b0;
  endtask : t_startup
  task automatic t_userid();
    logic [31:0] d;
    done = 1'b0;
    i_jtag_ctrl_model.scan(1'b1, 5, 32'h0000_0008, d);
    shifts = 0;
    i_jtag_ctrl_model.scan(1'b0, 32, 32'h0000_0000, d);
    chk("userid_early", d, 32'hffff_ffff);
    chk("dr_shifts", 32'(shifts), 32'h0000_0020);
    chk("dr_tdi", 32'(dr_tdi), 32'h0000_0001);
    done = 1'b1;
    i_jtag_ctrl_model.scan(1'b0, 32, 32'h0000_0000, d);
    chk("userid", d, USER_WORD);
  endtask : t_userid
  // Float, then a controller reset must bring back the id path
  task automatic t_id_reset();
    logic [31:0] d;
    i_jtag_ctrl_model.scan(1'b1, 5, 32'h0000_000a, d);
    i_jtag_ctrl_model.reset_tap();
    chk("highz_cleared", 32'(highz), 32'h0000_0000);
    i_jtag_ctrl_model.scan(1'b0, 32, 32'h0000_0000, d);
    chk("id_word", d, ID_WORD);
  endtask : t_id_reset
  // ********************************
  // Clock, reset, sequence, watchdog
  // ********************************
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    sys_rst_in = 1'b1;
    done = 1'b1;
    clk_sel = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    t_power_on();
    t_decode();
    t_startup();
    t_userid();
    t_id_reset();
    end_sim();
  end
  // Whole run needs well under 1 ms
  initial begin
    #1_000_000;
    errors++;
    end_sim();
  end
endmodule : tb_scan_decode
`default_nettype wire
